//--- src/asf_pkg.sv
// ****************************************************************
// shared constants for the scan select and result format block
// ****************************************************************
package asf_pkg;
    // register byte offsets
    localparam logic [3:0] OFF_CTRL = 4'h0;
    localparam logic [3:0] OFF_MASK = 4'h4;
    localparam logic [3:0] OFF_STAT = 4'h8;
    localparam logic [3:0] OFF_RSLT = 4'hC;
    // control field positions
    localparam int FRACTIONAL_OUTPUT_SELECT_BIT = 23;
    localparam int RES_LSB = 21;
    localparam int RES_MSB = 22;
    // reset values
    localparam logic FRACTIONAL_OUTPUT_SELECT_RST = 1'b0;
    localparam logic [1:0] RES_RST = 2'h3;
    localparam logic [31:0] MASK_RST = 32'h0000_0000;
    // resolution codes
    localparam logic [1:0] RES_12 = 2'h3;
    localparam logic [1:0] RES_10 = 2'h2;
    localparam logic [1:0] RES_8 = 2'h1;
    localparam logic [1:0] RES_6 = 2'h0;
    // inputs present on each package
    localparam logic [31:0] AVAIL_FULL = 32'hFFFF_FFFF;
    localparam logic [31:0] AVAIL_SMALL = 32'h0007_FFFF;
    // status field positions
    localparam int STAT_BUSY_BIT = 8;
    localparam int STAT_IDX_LSB = 0;
endpackage : asf_pkg

//--- src/asf_fmt_if.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// carrier between the scanner and the result formatter
// ****************************************************************
interface asf_fmt_if;
    logic [11:0] raw;
    logic [1:0] res;
    logic fractional_output_select;
    logic [15:0] word;
    modport scan (output raw, output res, output fractional_output_select, input word);
    modport fmt (input raw, input res, input fractional_output_select, output word);
endinterface : asf_fmt_if
`default_nettype wire

//--- src/asf_result_fmt.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// result formatter
// ****************************************************************
module asf_result_fmt (
    // formatter side of the carrier
    asf_fmt_if.fmt f
);
    // keep-mask for the 12-bit word at a given resolution
    function automatic logic [11:0] asf_keep(input logic [1:0] res);
        case (res)
            asf_pkg::RES_12: asf_keep = 12'hFFF;
            asf_pkg::RES_10: asf_keep = 12'hFFC;
            asf_pkg::RES_8: asf_keep = 12'hFF0;
            default: asf_keep = 12'hFC0;
        endcase
    endfunction : asf_keep

    // never shift on a resolution change; only clear unused low bits
    wire logic [11:0] kept;
    assign kept = f.raw & asf_keep(f.res);
    // fractional left-justifies in 16 bits, integer sits low
    assign f.word = f.fractional_output_select ? {kept, 4'h0} : {4'h0, kept};
endmodule : asf_result_fmt
`default_nettype wire

//--- src/asf_top.sv
// Contract
// - a format control of 1 gives fractional results and 0 gives integer results.
// - the two-bit resolution code 11/10/01/00 selects 12/10/8/6 bit conversion.
// - after reset the resolution code selects 12-bit conversion.
// - lower resolutions keep the result in the upper bits of the 12-bit word with unused low bits zero.
// - a 32-bit scan mask holds one include bit per analog input, set includes and clear skips.
// - on the small package the mask bits for inputs 19 to 31 do not exist.
//
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module asf_top #(
    parameter bit SMALL_PKG = 1'b0,
    parameter int N_IN = 32
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // register port
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rdata,
    // scan trigger from the trigger logic
    input wire logic scan_trigger,
    // shared converter
    output logic conv_start,
    output logic [4:0] conv_channel,
    output logic [1:0] shared_resolution_select,
    input wire logic conv_done,
    input wire logic [11:0] conv_raw,
    // formatted result
    output logic result_valid,
    output logic [4:0] result_channel,
    output logic [15:0] conversion_result_word
);
    // ************************************************************
    // register file
    // ************************************************************
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_FIND,
        ST_WAIT
    } asf_state_t;

    localparam logic [31:0] AVAIL = SMALL_PKG ? asf_pkg::AVAIL_SMALL : asf_pkg::AVAIL_FULL;
    localparam logic [4:0] LAST_IDX = 5'(N_IN - 1);

    logic fractional_output_select_q;
    logic [1:0] res_q;
    logic [31:0] mask_q;
    logic [31:0] rdata_q;
    asf_state_t state_q, state_d;
    logic [4:0] idx_q, idx_d;
    logic start_q;
    logic valid_q;
    logic [4:0] rchan_q;
    logic [15:0] word_q;
    logic [1:0] scan_res_q;
    logic scan_fractional_output_select_q;

    // address decode
    wire logic hit_ctrl;
    wire logic hit_mask;
    wire logic hit_stat;
    wire logic hit_rslt;
    assign hit_ctrl = addr == asf_pkg::OFF_CTRL;
    assign hit_mask = addr == asf_pkg::OFF_MASK;
    assign hit_stat = addr == asf_pkg::OFF_STAT;
    assign hit_rslt = addr == asf_pkg::OFF_RSLT;

    // control word image
    wire logic [31:0] ctrl_img;
    assign ctrl_img = (32'(fractional_output_select_q) << asf_pkg::FRACTIONAL_OUTPUT_SELECT_BIT) | (32'(res_q) << asf_pkg::RES_LSB);

    // status image: busy flag and current input
    wire logic busy;
    wire logic [31:0] stat_img;
    assign busy = state_q != ST_IDLE;
    assign stat_img = (32'(busy) << asf_pkg::STAT_BUSY_BIT) | (32'(idx_q) << asf_pkg::STAT_IDX_LSB);

    // read mux, unmapped reads give zero
    wire logic [31:0] rd_mux;
    assign rd_mux = hit_ctrl ? ctrl_img :
                    hit_mask ? mask_q :
                    hit_stat ? stat_img :
                    hit_rslt ? {16'h0000, word_q} : 32'h0000_0000;

    // control register
    always_ff @(posedge clk) begin
        if (reset) begin
            fractional_output_select_q <= asf_pkg::FRACTIONAL_OUTPUT_SELECT_RST;
            res_q <= asf_pkg::RES_RST;
        end else if (wr_en && hit_ctrl) begin
            fractional_output_select_q <= wdata[asf_pkg::FRACTIONAL_OUTPUT_SELECT_BIT];
            res_q <= wdata[asf_pkg::RES_MSB:asf_pkg::RES_LSB];
        end
    end

    // mask register; absent bits never store, so they read zero
    always_ff @(posedge clk) begin
        if (reset) begin
            mask_q <= asf_pkg::MASK_RST;
        end else if (wr_en && hit_mask) begin
            mask_q <= wdata & AVAIL;
        end
    end

    // read data stands one cycle after the strobe only
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= rd_en ? rd_mux : 32'h0000_0000;
        end
    end
    assign rdata = rdata_q;

    // ************************************************************
    // scan sequencer
    // ************************************************************
    // triggers during a scan are dropped: overlapping scans would
    // reorder inputs and that has no defined meaning
    wire logic sel_bit;
    wire logic at_last;
    assign sel_bit = mask_q[idx_q];
    assign at_last = idx_q == LAST_IDX;

    // next-state logic
    always_comb begin
        state_d = state_q;
        idx_d = idx_q;
        case (state_q)
            ST_IDLE: begin
                if (scan_trigger) begin
                    state_d = ST_FIND;
                    idx_d = 5'h00;
                end
            end
            ST_FIND: begin
                if (sel_bit) begin
                    state_d = ST_WAIT;
                end else if (at_last) begin
                    state_d = ST_IDLE;
                end else begin
                    idx_d = idx_q + 5'h01;
                end
            end
            ST_WAIT: begin
                if (conv_done) begin
                    if (at_last) begin
                        state_d = ST_IDLE;
                    end else begin
                        state_d = ST_FIND;
                        idx_d = idx_q + 5'h01;
                    end
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // state registers
    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= ST_IDLE;
            idx_q <= 5'h00;
        end else begin
            state_q <= state_d;
            idx_q <= idx_d;
        end
    end

    // one start pulse per included input
    always_ff @(posedge clk) begin
        if (reset) begin
            start_q <= 1'b0;
        end else begin
            start_q <= (state_q == ST_FIND) && sel_bit;
        end
    end
    assign conv_start = start_q;
    assign conv_channel = idx_q;

    // resolution and format latched per scan so a mid-scan write
    // cannot mix formats inside one scan
    always_ff @(posedge clk) begin
        if (reset) begin
            scan_res_q <= asf_pkg::RES_RST;
            scan_fractional_output_select_q <= asf_pkg::FRACTIONAL_OUTPUT_SELECT_RST;
        end else if (state_q == ST_IDLE) begin
            scan_res_q <= res_q;
            scan_fractional_output_select_q <= fractional_output_select_q;
        end
    end
    assign shared_resolution_select = scan_res_q;

    // ************************************************************
    // result formatting
    // ************************************************************
    asf_fmt_if fmt_bus ();
    assign fmt_bus.raw = conv_raw;
    assign fmt_bus.res = scan_res_q;
    assign fmt_bus.fractional_output_select = scan_fractional_output_select_q;

    asf_result_fmt u_fmt (
        .f(fmt_bus)
    );

    // capture each finished conversion
    always_ff @(posedge clk) begin
        if (reset) begin
            valid_q <= 1'b0;
            rchan_q <= 5'h00;
            word_q <= 16'h0000;
        end else begin
            valid_q <= (state_q == ST_WAIT) && conv_done;
            if ((state_q == ST_WAIT) && conv_done) begin
                rchan_q <= idx_q;
                word_q <= fmt_bus.word;
            end
        end
    end
    assign result_valid = valid_q;
    assign result_channel = rchan_q;
    assign conversion_result_word = word_q;
endmodule : asf_top
`default_nettype wire

//--- bench/asf_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// scan and result format checker
// ****************************************************************
module asf_checker (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // watched ports
    input wire logic rd_en,
    input wire logic [31:0] rdata,
    input wire logic conv_start,
    input wire logic [4:0] conv_channel,
    input wire logic [1:0] shared_resolution_select,
    input wire logic conv_done,
    input wire logic result_valid,
    input wire logic [4:0] result_channel,
    input wire logic [15:0] conversion_result_word
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // a formatted result lands one cycle after the converter answers
    sequence s_result;
        ##1 result_valid;
    endsequence
    chk_done_result: assert property (conv_done |-> s_result)
        else $error("no result after conversion");
    chk_valid_cause: assert property (result_valid |-> $past(conv_done))
        else $error("result without conversion");
    chk_start_single: assert property (conv_start |=> !conv_start && $stable(conv_channel))
        else $error("start pulse too long or channel moved");
    chk_result_chan: assert property (result_valid |-> result_channel == $past(conv_channel))
        else $error("result channel wrong");
    chk_res_reset: assert property ($fell(reset) |-> shared_resolution_select == 2'h3)
        else $error("resolution not full after reset");
    chk_low_zero: assert property (result_valid && shared_resolution_select == 2'h0 |->
        conversion_result_word[5:0] == 6'h00)
        else $error("unused low bits not zero");
    chk_word_fmt: assert property (result_valid |->
        conversion_result_word[15:12] == 4'h0 || conversion_result_word[3:0] == 4'h0)
        else $error("result word layout wrong");
    chk_rdata_idle: assert property (!$past(rd_en) |-> rdata == 32'h0000_0000)
        else $error("read data outside read cycle");
endmodule : asf_checker
bind asf_top asf_checker i_chk (.clk, .reset, .rd_en, .rdata, .conv_start, .conv_channel,
    .shared_resolution_select, .conv_done, .result_valid, .result_channel, .conversion_result_word);
`default_nettype wire

//--- bench/test_adc_scan_select_and_result_format.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// scan select and result format bench
// ****************************************************************
module test_adc_scan_select_and_result_format;
    logic clk, reset, wr_en, rd_en, scan_trigger, conv_start, conv_done, result_valid, rd_q;
    logic [3:0] addr;
    logic [31:0] wdata, rdata, rdata_small, seed, mask;
    logic [4:0] conv_channel, result_channel;
    logic [1:0] shared_resolution_select;
    logic [11:0] conv_raw;
    logic [15:0] conversion_result_word;
    logic [31:0] rexp[$];
    logic [31:0] rexp_s[$];
    logic [15:0] last_w;
    logic [20:0] exp_q[$];
    logic [11:0] raws[$];
    int error_cnt = 0;
    int total_checks = 0;
    asf_top i_dut (.clk, .reset, .addr, .wdata, .wr_en, .rd_en, .rdata, .scan_trigger, .conv_start,
        .conv_channel, .shared_resolution_select, .conv_done, .conv_raw, .result_valid,
        .result_channel, .conversion_result_word);
    // small package variant for the register side only; it never scans, so its scan inputs stay idle
    asf_top #(.SMALL_PKG(1'b1)) i_dut_small (.clk, .reset, .addr, .wdata, .wr_en, .rd_en,
        .rdata(rdata_small), .scan_trigger(1'b0), .conv_start(), .conv_channel(),
        .shared_resolution_select(), .conv_done(1'b0), .conv_raw(12'h000), .result_valid(),
        .result_channel(), .conversion_result_word());
    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    function logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr
    // low bits cleared per resolution, then placed by format
    function logic [15:0] fmt(input logic [11:0] raw, input logic [1:0] res, input logic fr);
        logic [11:0] k;
        k = raw & (res == 2'h3 ? 12'hFFF : res == 2'h2 ? 12'hFFC : res == 2'h1 ? 12'hFF0 : 12'hFC0);
        return fr ? {k, 4'h0} : {4'h0, k};
    endfunction : fmt
    task chk(input string n, input logic [31:0] e, input logic [31:0] s);
        total_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr
    task rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        rexp.push_back(e);
        // small part: absent mask bits read zero, status and result stay at reset
        rexp_s.push_back(a == asf_pkg::OFF_MASK ? e & 32'h0007_FFFF : a == asf_pkg::OFF_CTRL ? e : 32'h0);
        @(posedge clk);
        rd_en <= 1'b0;
    endtask : rd
    task complete_run;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : complete_run
    // compare read data and results with the oldest notes
    always @(posedge clk) begin
        rd_q <= rd_en;
        if (rd_q === 1'b1) chk("rdata", rexp.pop_front(), rdata);
        if (rd_q === 1'b1) chk("rdata small", rexp_s.pop_front(), rdata_small);
        if (result_valid === 1'b1) begin
            if (exp_q.size() == 0) chk("extra result", 32'h0, 32'h1);
            else chk("result", {11'h0, exp_q.pop_front()}, {11'h0, result_channel, conversion_result_word});
        end
    end
    // converter answers each start two cycles later
    initial begin
        conv_done = 1'b0;
        conv_raw = 12'h000;
        forever begin
            @(posedge clk);
            if (conv_start === 1'b1) begin
                repeat (2) @(posedge clk);
                conv_raw <= raws.pop_front();
                conv_done <= 1'b1;
                @(posedge clk);
                conv_done <= 1'b0;
                conv_raw <= ~conv_raw;
            end
        end
    end
    // watchdog well beyond eight full scans
    initial begin
        #300000;
        error_cnt++;
        complete_run();
    end
    initial begin
        {reset, wr_en, rd_en, scan_trigger, addr, wdata} = {1'b1, 39'h0};
        seed = 32'h812DBC4B;
        last_w = 16'h0000;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        rd(asf_pkg::OFF_CTRL, 32'h0060_0000);
        rd(asf_pkg::OFF_MASK, 32'h0);
        rd(4'h2, 32'h0);
        rd(asf_pkg::OFF_STAT, 32'h0);
        rd(asf_pkg::OFF_RSLT, 32'h0);
        for (int r = 0; r < 8; r++) begin
            seed = lfsr(seed);
            mask = seed;
            wr(asf_pkg::OFF_MASK, mask);
            rd(asf_pkg::OFF_MASK, mask);
            wr(asf_pkg::OFF_CTRL, {8'h0, r[2:0], 21'h0});
            rd(asf_pkg::OFF_CTRL, {8'h0, r[2:0], 21'h0});
            for (int i = 0; i < 32; i++) begin
                if (mask[i]) begin
                    seed = lfsr(seed);
                    raws.push_back(seed[11:0]);
                    exp_q.push_back({i[4:0], fmt(seed[11:0], r[1:0], r[2])});
                    last_w = fmt(seed[11:0], r[1:0], r[2]);
                end
            end
            // the scan trigger is the only conversion request the bench ever raises
            @(posedge clk) scan_trigger <= 1'b1;
            @(posedge clk) scan_trigger <= 1'b0;
            repeat (3) @(posedge clk);
            chk("resolution", {30'h0, r[1:0]}, {30'h0, shared_resolution_select});
            scan_trigger <= 1'b1;
            @(posedge clk) scan_trigger <= 1'b0;
            for (int k = 0; k < 600 && exp_q.size() > 0; k++) @(posedge clk);
            repeat (40) @(posedge clk);
            // a result that never came counts here, then the notes start afresh
            chk("pending results", 32'h0, exp_q.size());
            exp_q.delete();
            raws.delete();
            rd(asf_pkg::OFF_STAT, 32'h0000_001F);
            rd(asf_pkg::OFF_RSLT, {16'h0000, last_w});
        end
        complete_run();
    end
endmodule : test_adc_scan_select_and_result_format
`default_nettype wire
